// >>> bench/test_qct_top.sv
/*
 Self-checking bench of the quad counter/timer/PWM block: reset values,
 register access, clock sources, compare, chaining, capture and PWM duty.
 Assumes the block's package and defines header are compiled first.
*/
`timescale 1ns/100ps
`include "qct_defines.svh"
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin bad_count++; $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end

module test_qct_top
    import qct_pkg::*;
;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [3:0] ext_clock_pins = 4'h0;
    logic [3:0] int_clock_a = 4'h0;
    logic [3:0] int_clock_b = 4'h0;
    logic div128_clock = 1'b0;
    logic [3:0] snapshot_sources = 4'h0;
    logic pulse_pin0, pulse_pin1, pulse_pin0_active, pulse_pin1_active;
    logic [3:0] irq_v;
    logic [3:0] irq_p = 4'h0;
    logic [7:0] irq_upper_bank, irq_lower_bank, event_bank;
    int bad_count = 0;
    int checked = 0;
    int irq_n [4] = '{0, 0, 0, 0};

    always #20 clk_sys = ~clk_sys;

    qct_top uut (.clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .ext_clock_pins(ext_clock_pins), .int_clock_a(int_clock_a),
        .int_clock_b(int_clock_b), .div128_clock(div128_clock),
        .snapshot_sources(snapshot_sources), .pulse_pin0(pulse_pin0),
        .pulse_pin1(pulse_pin1), .pulse_pin0_active(pulse_pin0_active),
        .pulse_pin1_active(pulse_pin1_active),
        .first_counter_irq(irq_v[0]), .second_counter_irq(irq_v[1]),
        .third_counter_irq(irq_v[2]), .fourth_counter_irq(irq_v[3]),
        .irq_upper_bank(irq_upper_bank), .irq_lower_bank(irq_lower_bank),
        .event_bank(event_bank));

    // Every cycle the banks must mirror the four lines exactly.
    always @(posedge clk_sys) begin
        irq_p <= irq_v;
        if (nrst) begin
            for (int i = 0; i < 4; i++) begin
                irq_n[i] += (irq_v[i] === 1'b1);
            end
            `CHK("upper bank", {3'h0, irq_v[0], irq_v[2], 3'h0}, irq_upper_bank)
            `CHK("lower bank", {2'h0, irq_v[1], irq_v[3], 4'h0}, irq_lower_bank)
            `CHK("event bank", {irq_v[0], irq_v[2], 2'h0, irq_v[1], irq_v[3], 2'h0}, event_bank)
            `CHK("irq single cycle", 4'h0, irq_v & irq_p)
        end
    end

    task end_sim;
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Entered right after a rising edge; returns right after one.
    task automatic bus(input logic rd, input logic [5:0] a,
            input logic [7:0] d, input logic [3:0] be, output logic [7:0] q);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= {24'h00_0000, d};
        avs_byteenable <= be;
        avs_read <= rd;
        avs_write <= !rd;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0) begin
            bad_count++;
            end_sim();
        end
        q = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b0, a, d, 4'hf, q);
    endtask

    task automatic rd(input logic [5:0] a, output logic [7:0] q);
        bus(1'b1, a, 8'h00, 4'hf, q);
    endtask

    task automatic src(input int c, input logic [1:0] code, input logic v);
        case (code)
            2'h0: ext_clock_pins[c] <= v;
            2'h1: int_clock_a[c] <= v;
            2'h2: int_clock_b[c] <= v;
            default: div128_clock <= v;
        endcase
    endtask

    // One source rising edge per step, long enough for the count to land.
    task automatic step(input int c, input logic [1:0] code, input int n);
        for (int i = 0; i < n; i++) begin
            src(c, code, 1'b1);
            @(posedge clk_sys);
            src(c, code, 1'b0);
            repeat (3) @(posedge clk_sys);
        end
    endtask

    function automatic logic [7:0] cap_exp(input int f, input int na);
        return (f == 1) ? 8'(na) : 8'(na + 1);
    endfunction

    // Over one full wrap every count value appears once, so the number of
    // high samples equals the masked compare value whatever the start.
    task automatic pwm_chk(input int o);
        logic [7:0] c, b;
        int hi, ex, i0, span, w;
        c = 8'($urandom % 254 + 1);
        b = 8'($urandom);
        wr(`QCT_OFF_CFG1, (o == 2) ? 8'h05 : ((o == 1) ? 8'h02 : 8'h01));
        w = $urandom % 2;
        if (o == 2) begin
            wr(`QCT_OFF_CFG2, 8'(w));
            wr(`QCT_OFF_CNT_B, b);
        end
        wr((o == 1) ? `QCT_OFF_CNT_C : `QCT_OFF_CNT_A, c);
        wr(`QCT_OFF_RUN, (o == 1) ? 8'h04 : 8'h01);
        span = (o == 2) ? (1024 << (2 * w)) : 256;
        ex = (o == 2) ? int'({b, c}) % span : int'(c);
        i0 = irq_n[(o == 1) ? 2 : 0];
        hi = 0;
        for (int i = 0; i < span; i++) begin
            step((o == 1) ? 2 : 0, 2'h0, 1);
            hi += ((o == 1) ? pulse_pin1 === 1'b1 : pulse_pin0 === 1'b1);
        end
        `CHK("pwm owns pin", 1'b1, (o == 1) ? pulse_pin1_active : pulse_pin0_active)
        `CHK("pwm duty", ex, hi)
        `CHK("no irq in pwm", i0, irq_n[(o == 1) ? 2 : 0])
        wr(`QCT_OFF_RUN, 8'h00);
    endtask

    initial begin
        logic [7:0] q, v, c;
        int n, na, nb, sel, i0, i3, seed;
        seed = $urandom(32'hcb9fc194);
        repeat (16) @(posedge clk_sys);
        `CHK("wait in reset", 1'b1, avs_waitrequest)
        nrst <= 1'b1;
        @(posedge clk_sys);
        `CHK("pin0 idle", 2'h0, {pulse_pin0, pulse_pin0_active})
        rd(`QCT_OFF_RUN, q); `CHK("run reset", 8'h00, q)
        rd(`QCT_OFF_CFG1, q); `CHK("cfg1 reset", 2'h0, q[1:0])
        rd(`QCT_OFF_CFG2, q); `CHK("cfg2 reset", 4'h0, q[7:4])
        rd(6'h20, q); `CHK("unmapped read", 8'h00, q)
        v = 8'($urandom);
        wr(`QCT_OFF_CLKSEL, v);
        bus(1'b0, `QCT_OFF_CLKSEL, ~v, 4'he, q);
        rd(`QCT_OFF_CLKSEL, q); `CHK("clock select", v, q)
        v = 8'($urandom) & 8'hfc;
        wr(`QCT_OFF_CFG1, v);
        rd(`QCT_OFF_CFG1, q); `CHK("cfg1", v, q)
        v = 8'($urandom);
        wr(`QCT_OFF_CFG2, v);
        rd(`QCT_OFF_CFG2, q); `CHK("cfg2", v, q)
        wr(`QCT_OFF_RUN, 8'hff);
        rd(`QCT_OFF_RUN, q); `CHK("run reserved", 8'h0f, q)
        wr(6'h24, 8'h5a);
        rd(6'h24, q); `CHK("unmapped write", 8'h00, q)
        wr(`QCT_OFF_RUN, 8'h00);
        wr(`QCT_OFF_CFG1, 8'h10);
        wr(`QCT_OFF_CFG2, 8'h00);
        wr(`QCT_OFF_RUN, 8'h01);
        for (int k = 0; k < 4; k++) begin
            wr(`QCT_OFF_CLKSEL, 8'(k));
            wr(`QCT_OFF_CNT_A, 8'hff);
            n = 1 + $urandom % 20;
            step(0, 2'(k), n);
            rd(`QCT_OFF_CNT_A, q); `CHK("count per source", 8'(n), q)
        end
        wr(`QCT_OFF_RUN, 8'h00);
        step(0, 2'h3, 4);
        rd(`QCT_OFF_CNT_A, q); `CHK("stopped count", 8'(n), q)
        wr(`QCT_OFF_CLKSEL, 8'h00);
        c = 8'(2 + $urandom % 8);
        wr(`QCT_OFF_CNT_A, c);
        wr(`QCT_OFF_CNT_D, c);
        wr(`QCT_OFF_RUN, 8'h09);
        i0 = irq_n[0];
        i3 = irq_n[3];
        step(0, 2'h0, c + 1);
        step(3, 2'h0, c + 1);
        rd(`QCT_OFF_CNT_A, q); `CHK("up wrap", 8'h00, q)
        rd(`QCT_OFF_CNT_D, q); `CHK("down reload", c, q)
        rd(`QCT_OFF_CNT_C, q); `CHK("live c", 8'h00, q)
        `CHK("irq a count", i0 + 1, irq_n[0])
        `CHK("irq d count", i3 + 1, irq_n[3])
        wr(`QCT_OFF_RUN, 8'h00);
        wr(`QCT_OFF_CFG1, 8'h14);
        wr(`QCT_OFF_CNT_B, 8'h01);
        wr(`QCT_OFF_CNT_A, 8'hff);
        wr(`QCT_OFF_RUN, 8'h01);
        n = $urandom % 8;
        step(0, 2'h0, 256 + n);
        rd(`QCT_OFF_CNT_A, q); `CHK("chain low", 8'(n), q)
        rd(`QCT_OFF_CNT_B, q); `CHK("chain high", 8'h01, q)
        wr(`QCT_OFF_RUN, 8'h00);
        wr(`QCT_OFF_CFG1, 8'h30);
        wr(`QCT_OFF_CLKSEL, 8'h04);
        for (int f = 1; f < 4; f++) begin
            sel = $urandom % 4;
            wr(`QCT_OFF_CFG2, {2'(sel), 2'(f), 4'h0});
            wr(`QCT_OFF_CNT_A, 8'hff);
            wr(`QCT_OFF_CNT_B, 8'hff);
            wr(`QCT_OFF_RUN, 8'h03);
            na = 1 + $urandom % 9;
            nb = 1 + $urandom % 9;
            step(0, 2'h0, na);
            step(1, 2'h1, nb);
            i0 = irq_n[1];
            snapshot_sources[sel] <= 1'b1;
            repeat (4) @(posedge clk_sys);
            step(0, 2'h0, 1);
            snapshot_sources[sel] <= 1'b0;
            repeat (4) @(posedge clk_sys);
            step(0, 2'h0, 2);
            step(1, 2'h1, 2);
            rd(`QCT_OFF_CNT_A, q); `CHK("capture a", cap_exp(f, na), q)
            rd(`QCT_OFF_CNT_B, q); `CHK("capture b", 8'(nb), q)
            `CHK("capture irq b", i0 + ((f == 3) ? 2 : 1), irq_n[1])
            wr(`QCT_OFF_RUN, 8'h00);
        end
        wr(`QCT_OFF_CFG2, 8'h00);
        rd(`QCT_OFF_CNT_A, q); `CHK("live after capture", 8'(na + 3), q)
        wr(`QCT_OFF_CLKSEL, 8'h00);
        for (int o = 0; o < 3; o++) begin
            pwm_chk(o);
        end
        end_sim();
    end
endmodule

// >>> pkg/qct_defines.svh
/*
 Register offsets, field positions and reset values of the quad
 counter/timer/PWM block. Assumes inclusion by bare name from a design
 file; holds definitions only.
*/
`ifndef QCT_DEFINES_SVH
`define QCT_DEFINES_SVH

`define QCT_OFF_CNT_A 6'h00
`define QCT_OFF_CNT_B 6'h04
`define QCT_OFF_CNT_C 6'h08
`define QCT_OFF_CNT_D 6'h0C
`define QCT_OFF_CLKSEL 6'h10
`define QCT_OFF_CFG1 6'h14
`define QCT_OFF_CFG2 6'h18
`define QCT_OFF_RUN 6'h1C

`define QCT_CFG1_DIR_LSB 4
`define QCT_CFG1_CHAIN_LSB 2
`define QCT_CFG1_PWM_LSB 0
`define QCT_CFG2_SNAPSHOT_SOURCE_CHOICE_LSB 6
`define QCT_CFG2_CAPFN_LSB 4
`define QCT_CFG2_PWSEL_LSB 0

`define QCT_RST_BYTE 8'h00
`define QCT_RST_WAIT 1'b1

`endif

// >>> pkg/qct_pkg.sv
/*
 Types of the quad counter/timer/PWM block: clock source codes and
 capture edge functions. Assumes nothing of its surroundings.
*/
package qct_pkg;

    typedef enum logic [1:0] {
        QCT_CK_PIN = 2'h0,
        QCT_CK_INT_A = 2'h1,
        QCT_CK_INT_B = 2'h2,
        QCT_CK_DIV128 = 2'h3
    } qct_clksel_e;

    typedef enum logic [1:0] {
        QCT_CAP_OFF = 2'h0,
        QCT_CAP_RISE = 2'h1,
        QCT_CAP_FALL = 2'h2,
        QCT_CAP_BOTH = 2'h3
    } qct_capfn_e;

endpackage

// >>> src/qct_top.sv
/*
 Four 8-bit counter/timers with pair chaining, capture on the first
 pair and two pulse-width outputs, behind an Avalon-MM slave.
 Assumes all clock-source and capture inputs are synchronous levels of
 clk_sys; pin debouncing lives in the port A logic outside.
*/
// The placing of the registers and the Avalon-MM interface to the registers are this design's own decisions.
// Functional notes
// [RL1] Four 8-bit counters; pairs A-B and C-D may chain to 16 bits.
// [RL2] Two pulse-width outputs on port B, width 8,10,12,14 or 16 bits.
// [RL3] One shared capture event snapshots counters A and B together.
// [RL4] Unchained A and B may use different clocks while captured.
// [RL5] Unchained A-B: counters, captured, PWM plus counter or captured.
// [RL6] Unchained C-D: two counters, or C as PWM with D counting.
// [RL7] A/B writes set compare; reads give count, or capture if active.
// [RL8] C/D writes set compare; reads always give live count.
// [RL9] Clock select holds four 2-bit selectors, D high down to A low.
// [RL10] Four sources per counter; port A low pins as external clocks.
// [RL11] Config one bits 7..4 set direction of D..A; one means up.
// [RL12] Config one bit 3 chains C-D, bit 2 chains A-B.
// [RL13] Config one bits 1 and 0 enable pulse outputs one and zero.
// [RL14] Config two holds capture source 7-6 and function 5-4, reset 0.
// [RL15] Config two holds pulse width selects: out1 3-2, out0 1-0.
// [RL16] Capture from chosen source on rising, falling or both edges.
// [RL17] Counter lines map to interrupt and event bank bits.
// [RL18] Counters run only when enabled; low enable governs chained high.
// [RL19] Counter-mode write clears up-count or loads down-count; PWM not.
// [RL20] Selector 00 own pin, 01/10 internal clocks, 11 divided clock.
// [RL21] Software changes sources and modes only while stopped.
// [RL22] Each counter line pulses one cycle on compare or capture.
`timescale 1ns/100ps
`include "qct_defines.svh"

module qct_top
    import qct_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [3:0] ext_clock_pins,
    input wire logic [3:0] int_clock_a,
    input wire logic [3:0] int_clock_b,
    input wire logic div128_clock,
    input wire logic [3:0] snapshot_sources,
    output logic pulse_pin0,
    output logic pulse_pin1,
    output logic pulse_pin0_active,
    output logic pulse_pin1_active,
    output logic first_counter_irq,
    output logic second_counter_irq,
    output logic third_counter_irq,
    output logic fourth_counter_irq,
    output logic [7:0] irq_upper_bank,
    output logic [7:0] irq_lower_bank,
    output logic [7:0] event_bank
);

    logic [7:0] cnt_reg [4];
    logic [7:0] cmp_reg [4];
    logic [7:0] cap_reg [2];
    logic [7:0] counter_clock_select_reg;
    logic [7:0] counter_direction_chain_pwm_cfg_reg;
    logic [7:0] capture_and_pwm_width_cfg_reg;
    logic [3:0] counter_run_enables_reg;
    logic snap_prev_reg;
    wire logic [3:0] step_w;
    wire logic [3:0] term_w;
    wire logic [3:0] wrap_w;
    wire logic [3:0] event_w;
    wire logic [3:0] up_w;
    wire logic [3:0] pwm_here_w;
    wire logic [1:0] pwm_w;
    logic wr_acc;
    logic [7:0] rd_next;
    logic cap_on;
    logic snap_src;
    logic cap_evt;
    logic [3:0] irq_next;
    logic [3:0] widx;

    assign wr_acc = avs_write & ~avs_waitrequest & avs_byteenable[0];
    assign widx = avs_address[5:2];

    // One wait state on every access keeps read data a registered value.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            avs_waitrequest <= `QCT_RST_WAIT;
        end else begin
            avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
        end
    end

    always_comb begin
        rd_next = 8'h00;
        unique case (avs_address)
            `QCT_OFF_CNT_A: rd_next = cap_on ? cap_reg[0] : cnt_reg[0]; // RL7
            `QCT_OFF_CNT_B: rd_next = cap_on ? cap_reg[1] : cnt_reg[1]; // RL7
            `QCT_OFF_CNT_C: rd_next = cnt_reg[2]; // RL8
            `QCT_OFF_CNT_D: rd_next = cnt_reg[3]; // RL8
            `QCT_OFF_CLKSEL: rd_next = counter_clock_select_reg;
            `QCT_OFF_CFG1: rd_next = counter_direction_chain_pwm_cfg_reg;
            `QCT_OFF_CFG2: rd_next = capture_and_pwm_width_cfg_reg;
            `QCT_OFF_RUN: rd_next = {4'h0, counter_run_enables_reg};
            default: rd_next = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= {24'h00_0000, rd_next};
        end
    end

    // Fields without a defined reset value still clear, so that the
    // block never runs from an unknown mode.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            counter_clock_select_reg <= `QCT_RST_BYTE;
            counter_direction_chain_pwm_cfg_reg <= `QCT_RST_BYTE;
            capture_and_pwm_width_cfg_reg <= `QCT_RST_BYTE;
            counter_run_enables_reg <= 4'h0;
        end else if (wr_acc) begin
            if (avs_address == `QCT_OFF_CLKSEL) begin
                counter_clock_select_reg <= avs_writedata[7:0]; // RL9
            end
            if (avs_address == `QCT_OFF_CFG1) begin
                counter_direction_chain_pwm_cfg_reg <= avs_writedata[7:0];
            end
            if (avs_address == `QCT_OFF_CFG2) begin
                capture_and_pwm_width_cfg_reg <= avs_writedata[7:0];
            end
            if (avs_address == `QCT_OFF_RUN) begin
                counter_run_enables_reg <= avs_writedata[3:0]; // RL18
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_ch
            localparam int LO = gi & 2;
            localparam int PR = gi / 2;
            localparam bit HI = (gi % 2) == 1;
            logic chained;
            logic hi_ch;
            logic run;
            logic src;
            logic src_prev_reg;
            logic base_step;
            logic ch_inc;
            logic ch_rld;
            logic reload;
            logic inc;
            logic wr_hit;
            logic [7:0] cnt_next;

            assign chained = counter_direction_chain_pwm_cfg_reg[
                `QCT_CFG1_CHAIN_LSB + PR]; // RL12
            assign hi_ch = HI & chained;
            assign pwm_here_w[gi] = counter_direction_chain_pwm_cfg_reg[
                `QCT_CFG1_PWM_LSB + PR] & (!HI || chained); // RL13
            // PWM always counts down; a chained pair follows the low bit.
            assign up_w[gi] = ~pwm_here_w[gi]
                & counter_direction_chain_pwm_cfg_reg[`QCT_CFG1_DIR_LSB
                + (chained ? LO : gi)]; // RL11
            assign run = counter_run_enables_reg[hi_ch ? LO : gi]; // RL18

            always_comb begin
                unique case (counter_clock_select_reg[2*gi +: 2]) // RL20
                    QCT_CK_PIN: src = ext_clock_pins[gi]; // RL10
                    QCT_CK_INT_A: src = int_clock_a[gi];
                    QCT_CK_INT_B: src = int_clock_b[gi];
                    QCT_CK_DIV128: src = div128_clock;
                endcase
            end

            always_ff @(posedge clk_sys or negedge nrst) begin
                if (!nrst) begin
                    src_prev_reg <= 1'b0;
                end else begin
                    src_prev_reg <= src;
                end
            end

            assign base_step = run & src & ~src_prev_reg & ~hi_ch;
            assign wrap_w[gi] = up_w[gi] ? (cnt_reg[gi] == 8'hFF)
                : (cnt_reg[gi] == 8'h00);
            // A chained low counter ends on the whole 16-bit value.
            assign term_w[gi] = ~pwm_here_w[gi] & (chained
                ? (up_w[gi]
                    ? ({cnt_reg[LO+1], cnt_reg[LO]}
                        == {cmp_reg[LO+1], cmp_reg[LO]})
                    : ({cnt_reg[LO+1], cnt_reg[LO]} == 16'h0000))
                : (up_w[gi] ? (cnt_reg[gi] == cmp_reg[gi])
                    : (cnt_reg[gi] == 8'h00)));

            if (HI) begin : g_hi
                assign ch_inc = step_w[LO] & ~term_w[LO] & wrap_w[LO]; // RL1
                assign ch_rld = step_w[LO] & term_w[LO];
            end else begin : g_lo
                assign ch_inc = 1'b0;
                assign ch_rld = 1'b0;
            end

            assign step_w[gi] = hi_ch ? ch_inc : base_step;
            assign reload = ~pwm_here_w[gi]
                & (hi_ch ? ch_rld : base_step & term_w[gi]);
            assign inc = hi_ch ? ch_inc : base_step & ~reload;
            assign event_w[gi] = reload & ~hi_ch;
            assign wr_hit = wr_acc & (widx == 4'(gi));

            always_comb begin
                cnt_next = cnt_reg[gi];
                if (wr_hit && !pwm_here_w[gi]) begin
                    cnt_next = up_w[gi] ? 8'h00 : avs_writedata[7:0]; // RL19
                end else if (reload) begin
                    cnt_next = up_w[gi] ? 8'h00 : cmp_reg[gi];
                end else if (inc) begin
                    cnt_next = up_w[gi] ? 8'(cnt_reg[gi] + 8'h01)
                        : 8'(cnt_reg[gi] - 8'h01);
                end
            end

            always_ff @(posedge clk_sys or negedge nrst) begin
                if (!nrst) begin
                    cnt_reg[gi] <= `QCT_RST_BYTE;
                    cmp_reg[gi] <= `QCT_RST_BYTE;
                end else begin
                    cnt_reg[gi] <= cnt_next;
                    if (wr_hit) begin
                        cmp_reg[gi] <= avs_writedata[7:0]; // RL7 RL8
                    end
                end
            end
        end
    endgenerate

    // Chained PWM keeps the full 16-bit counter and masks for the width.
    function automatic logic [15:0] qct_pw_mask(input logic chain,
                                                 input logic [1:0] sel);
        logic [15:0] m;
        m = 16'h00FF;
        if (chain) begin
            unique case (sel)
                2'h0: m = 16'h03FF;
                2'h1: m = 16'h0FFF;
                2'h2: m = 16'h3FFF;
                2'h3: m = 16'hFFFF;
            endcase
        end
        return m;
    endfunction

    genvar gp;
    generate
        for (gp = 0; gp < 2; gp++) begin : g_pw
            logic [15:0] mask;
            assign mask = qct_pw_mask(
                counter_direction_chain_pwm_cfg_reg[`QCT_CFG1_CHAIN_LSB + gp],
                capture_and_pwm_width_cfg_reg[`QCT_CFG2_PWSEL_LSB + 2*gp +: 2]);
            assign pwm_w[gp] = ({cnt_reg[2*gp+1], cnt_reg[2*gp]} & mask)
                < ({cmp_reg[2*gp+1], cmp_reg[2*gp]} & mask); // RL2 RL15
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pulse_pin0 <= 1'b0;
            pulse_pin1 <= 1'b0;
            pulse_pin0_active <= 1'b0;
            pulse_pin1_active <= 1'b0;
        end else begin
            pulse_pin0_active <= pwm_here_w[0]; // RL13
            pulse_pin1_active <= pwm_here_w[2]; // RL13 RL6
            pulse_pin0 <= pwm_here_w[0] & pwm_w[0]; // RL2 RL5
            pulse_pin1 <= pwm_here_w[2] & pwm_w[1]; // RL2
        end
    end

    assign cap_on = capture_and_pwm_width_cfg_reg[`QCT_CFG2_CAPFN_LSB +: 2]
        != QCT_CAP_OFF; // RL14
    assign snap_src = snapshot_sources[
        capture_and_pwm_width_cfg_reg[`QCT_CFG2_SNAPSHOT_SOURCE_CHOICE_LSB +: 2]];

    always_comb begin
        unique case (capture_and_pwm_width_cfg_reg[`QCT_CFG2_CAPFN_LSB +: 2])
            QCT_CAP_OFF: cap_evt = 1'b0;
            QCT_CAP_RISE: cap_evt = snap_src & ~snap_prev_reg; // RL16
            QCT_CAP_FALL: cap_evt = ~snap_src & snap_prev_reg; // RL16
            QCT_CAP_BOTH: cap_evt = snap_src ^ snap_prev_reg; // RL16
        endcase
    end

    // Both counters take the same snapshot, whatever clocks them.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            snap_prev_reg <= 1'b0;
            cap_reg[0] <= `QCT_RST_BYTE;
            cap_reg[1] <= `QCT_RST_BYTE;
        end else begin
            snap_prev_reg <= snap_src;
            if (cap_evt) begin
                cap_reg[0] <= cnt_reg[0]; // RL3 RL4
                cap_reg[1] <= cnt_reg[1]; // RL3 RL4
            end
        end
    end

    // With capture on, the first pair signals snapshots, not compares;
    // a PWM first counter gives no line of its own.
    assign irq_next[0] = cap_on ? cap_evt & ~pwm_here_w[0]
        : event_w[0] & ~pwm_here_w[0]; // RL22 RL5
    assign irq_next[1] = cap_on ? cap_evt : event_w[1]; // RL22
    assign irq_next[2] = event_w[2]; // RL22
    assign irq_next[3] = event_w[3]; // RL22

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            first_counter_irq <= 1'b0;
            second_counter_irq <= 1'b0;
            third_counter_irq <= 1'b0;
            fourth_counter_irq <= 1'b0;
            irq_upper_bank <= 8'h00;
            irq_lower_bank <= 8'h00;
            event_bank <= 8'h00;
        end else begin
            first_counter_irq <= irq_next[0];
            second_counter_irq <= irq_next[1];
            third_counter_irq <= irq_next[2];
            fourth_counter_irq <= irq_next[3];
            irq_upper_bank <= {3'h0, irq_next[0], irq_next[2], 3'h0}; // RL17
            irq_lower_bank <= {2'h0, irq_next[1], irq_next[3], 4'h0}; // RL17
            event_bank <= {irq_next[0], irq_next[2], 2'h0,
                irq_next[1], irq_next[3], 2'h0}; // RL17
        end
    end

    sequence s_rd_c;
        avs_read && avs_waitrequest && avs_address == `QCT_OFF_CNT_C;
    endsequence

    sequence s_rd_a_cap;
        avs_read && avs_waitrequest && cap_on
            && avs_address == `QCT_OFF_CNT_A;
    endsequence

    AST_READ_C_LIVE: assert property (@(posedge clk_sys) disable iff (!nrst) // RL8
        s_rd_c |=> !avs_waitrequest
            && avs_readdata[7:0] == $past(cnt_reg[2]))
        else $error("read of counter C not live count");

    AST_READ_A_CAPTURE: assert property (@(posedge clk_sys) disable iff (!nrst) // RL7
        s_rd_a_cap |=> avs_readdata[7:0] == $past(cap_reg[0]))
        else $error("read of counter A not captured value");

    AST_WRITE_UP_CLEARS: assert property (@(posedge clk_sys) disable iff (!nrst) // RL19
        wr_acc && widx == 4'h0 && up_w[0] && !pwm_here_w[0]
            |=> cnt_reg[0] == 8'h00)
        else $error("up-count write did not clear counter A");

    AST_WRITE_DOWN_LOADS: assert property (@(posedge clk_sys) disable iff (!nrst) // RL19
        wr_acc && widx == 4'h3 && !up_w[3] && !pwm_here_w[3]
            |=> cnt_reg[3] == $past(avs_writedata[7:0])
                && cmp_reg[3] == $past(avs_writedata[7:0]))
        else $error("down-count write did not load counter D");

    AST_STOPPED_FROZEN: assert property (@(posedge clk_sys) disable iff (!nrst) // RL18
        !counter_run_enables_reg[0] && !(wr_acc && widx == 4'h0)
            |=> $stable(cnt_reg[0]))
        else $error("stopped counter A changed");

    AST_SNAPSHOT_BOTH: assert property (@(posedge clk_sys) disable iff (!nrst) // RL3
        cap_evt |=> cap_reg[0] == $past(cnt_reg[0])
            && cap_reg[1] == $past(cnt_reg[1]) && second_counter_irq)
        else $error("capture did not snapshot both counters");

    AST_CHAIN_CARRY: assert property (@(posedge clk_sys) disable iff (!nrst) // RL12
        counter_direction_chain_pwm_cfg_reg[`QCT_CFG1_CHAIN_LSB]
            && step_w[0] && wrap_w[0] && !term_w[0] && up_w[0]
            && !(wr_acc && widx == 4'h1)
            |=> cnt_reg[1] == 8'($past(cnt_reg[1]) + 8'h01))
        else $error("chained high counter missed carry");

    AST_BANK_MAP: assert property (@(posedge clk_sys) disable iff (!nrst) // RL17
        event_bank[7] == first_counter_irq
            && irq_upper_bank[3] == third_counter_irq
            && irq_lower_bank[5] == second_counter_irq
            && event_bank[2] == fourth_counter_irq)
        else $error("interrupt bank mapping wrong");

    AST_IRQ_PULSE: assert property (@(posedge clk_sys) disable iff (!nrst) // RL22
        fourth_counter_irq |=> !fourth_counter_irq)
        else $error("counter D line longer than one cycle");

    AST_PWM_OFF_LOW: assert property (@(posedge clk_sys) disable iff (!nrst) // RL13
        !pwm_here_w[0] |=> !pulse_pin0 && !pulse_pin0_active)
        else $error("pulse pin 0 driven while disabled");

endmodule
